/* File: hrc_cfg_monitor.sv */
// Checker for reset pad states and configuration source order
`timescale 1ns/1ps
module hrc_cfg_monitor
    import hrc_pkg::*;
#(
    parameter int unsigned N_CARD = CARD_PADS
) (
    // Clock, reset and handshakes
    input wire logic i_ref_clk, i_rstn, i_usb_cfg_wr_req, i_spi_load_done,
    input wire logic i_ee_load_done, i_def_load_done, o_spi_probe_req,
    input wire logic o_spi_load_req, o_ee_probe_req, o_ee_load_req, o_def_load_req,
    // Status and pads
    input wire logic o_usb_cfg_wr_allow, o_cfg_done, o_upstream_attach, o_spi_cs_n,
    input wire logic [1:0] o_cfg_source, o_tt_count, o_port_power_control_output,
    input wire logic [2:0] o_tt_np_buffers,
    input wire logic [N_CARD-1:0] o_card_pad_oe, o_card_fn_in
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // Fixed translator figures
    property p_tt; o_tt_count == 2'h1 && o_tt_np_buffers == 3'h4; endproperty
    a_tt: assert property (p_tt) else $error("translator figures wrong");
    // Pads held quiet until attach
    property p_hold; !o_upstream_attach |-> o_spi_cs_n && o_port_power_control_output == 2'h0;
    endproperty
    a_hold: assert property (p_hold) else $error("select or power not held");
    property p_pad; !o_upstream_attach |-> o_card_pad_oe == '0 && o_card_fn_in == '0;
    endproperty
    a_pad: assert property (p_pad) else $error("card pad not disabled");
    // Attach only after a finished load
    property p_att; $rose(o_upstream_attach) |-> $past(o_spi_load_req && i_spi_load_done
        || o_ee_load_req && i_ee_load_done || o_def_load_req && i_def_load_done);
    endproperty
    a_att: assert property (p_att) else $error("attach without load");
    // EEPROM probed only after flash probe, defaults only after EEPROM probe
    property p_ee; $rose(o_ee_probe_req) |-> $past(o_spi_probe_req); endproperty
    a_ee: assert property (p_ee) else $error("EEPROM probe out of order");
    property p_def; $rose(o_def_load_req) |-> $past(o_ee_probe_req); endproperty
    a_def: assert property (p_def) else $error("defaults out of order");
    // Rewrite permission only with an external source
    property p_wr; o_usb_cfg_wr_allow == (i_usb_cfg_wr_req && o_upstream_attach
        && (o_cfg_source == SRC_SPI || o_cfg_source == SRC_EEPROM)); endproperty
    a_wr: assert property (p_wr) else $error("rewrite permission wrong");
    property p_cfg; o_upstream_attach |-> o_cfg_done && o_cfg_source != SRC_NONE; endproperty
    a_cfg: assert property (p_cfg) else $error("attached unconfigured");
    // Main outcomes
    c_spi: cover property (o_upstream_attach && o_cfg_source == SRC_SPI);
    c_ee: cover property (o_upstream_attach && o_cfg_source == SRC_EEPROM);
    c_def: cover property (o_upstream_attach && o_cfg_source == SRC_DEFAULT);
endmodule // hrc_cfg_monitor

bind hrc_config_select hrc_cfg_monitor #(.N_CARD(N_CARD)) u_mon (.*);

/* File: hrc_config_select.sv */
`timescale 1ns/1ps
// Configuration source selector and reset pad control for the hub
module hrc_config_select
    import hrc_pkg::*;
#(
    parameter int unsigned PROBE_CYCLES = PROBE_CYC,
    parameter int unsigned N_CARD       = CARD_PADS
) (
    // Clock and reset
    input  wire logic                i_ref_clk,
    input  wire logic                i_rstn,
    // SPI flash probe and load, with signature check result
    input  wire logic                i_spi_probe_done,
    input  wire logic                i_spi_sig_ok,
    input  wire logic                i_spi_load_done,
    output logic                     o_spi_probe_req,
    output logic                     o_spi_load_req,
    // Serial EEPROM probe and load
    input  wire logic                i_ee_probe_done,
    input  wire logic                i_ee_sig_ok,
    input  wire logic                i_ee_load_done,
    output logic                     o_ee_probe_req,
    output logic                     o_ee_load_req,
    // Built-in defaults load
    input  wire logic                i_def_load_done,
    output logic                     o_def_load_req,
    // Rewrite through USB
    input  wire logic                i_usb_cfg_wr_req,
    output logic                     o_usb_cfg_wr_allow,
    // Status
    output logic [1:0]               o_cfg_source,
    output logic                     o_cfg_done,
    output logic                     o_upstream_attach,
    output logic [1:0]               o_tt_count,
    output logic [2:0]               o_tt_np_buffers,
    // SPI chip select (active low)
    input  wire logic                i_spi_cs_n_fn,
    output logic                     o_spi_cs_n,
    // Port power control outputs
    input  wire logic [DN_PORTS-1:0] i_port_pwr_fn,
    output logic [DN_PORTS-1:0]      o_port_power_control_output,
    // Card media pads, six signals per pad: three on the function side, three on the pad side
    input  wire logic [N_CARD-1:0]   i_card_fn_out,
    input  wire logic [N_CARD-1:0]   i_card_fn_oe,
    output logic [N_CARD-1:0]        o_card_fn_in,
    input  wire logic [N_CARD-1:0]   i_card_pad_in,
    output logic [N_CARD-1:0]        o_card_pad_out,
    output logic [N_CARD-1:0]        o_card_pad_oe
);

    // Elaboration checks
    if (PROBE_CYCLES < 1) begin : g_chk_probe
        $error("PROBE_CYCLES must be at least one");
    end
    if (N_CARD < 1) begin : g_chk_card
        $error("N_CARD must be at least one");
    end
    if (TT_COUNT >= 2 ** $bits(o_tt_count)) begin : g_chk_tt
        $error("Translator count does not fit its status field");
    end
    if (TT_NP_BUFFERS >= 2 ** $bits(o_tt_np_buffers)) begin : g_chk_buf
        $error("Translator buffer count does not fit its status field");
    end

    localparam int unsigned TW = $clog2(PROBE_CYCLES + 1);
    localparam logic [TW-1:0] TMO = TW'(PROBE_CYCLES);

    hrc_state_t       state_q, state_d;
    logic [1:0]       src_q, src_d;
    logic [TW-1:0]    tmr_q;
    logic [TW-1:0]    tmr_d;

    // Pads stay in reset state until configuration is loaded
    logic  hold_w;
    assign hold_w = (state_q != HRC_ATTACHED);

    // Probe timeouts count as "no memory present"
    logic  tmo_w;
    logic  probing_w;
    assign tmo_w     = (tmr_q == TMO);
    assign probing_w = (state_q == HRC_PROBE_SPI) || (state_q == HRC_PROBE_EE);

    // Probe outcomes; the sequence only acts on them in the matching state
    logic  spi_found_w;
    logic  spi_absent_w;
    logic  ee_found_w;
    logic  ee_absent_w;
    assign spi_found_w  = i_spi_probe_done && i_spi_sig_ok;          // [RULE9]
    assign spi_absent_w = i_spi_probe_done || tmo_w;                 // [RULE9]
    assign ee_found_w   = i_ee_probe_done && i_ee_sig_ok;            // [RULE5]
    assign ee_absent_w  = i_ee_probe_done || tmo_w;                  // [RULE6]

    // Completion of the load that the current state waits for
    logic  load_fin_w;
    assign load_fin_w = ((state_q == HRC_LOAD_SPI) && i_spi_load_done)
                     || ((state_q == HRC_LOAD_EE) && i_ee_load_done)
                     || ((state_q == HRC_LOAD_DEF) && i_def_load_done); // [RULE8]

    // Next-state for the loader sequence; flash is always probed first
    always_comb begin
        state_d = state_q;
        src_d   = src_q;
        unique case (state_q)
            HRC_RESET: begin
                state_d = HRC_PROBE_SPI;                                 // [RULE9]
            end
            HRC_PROBE_SPI: begin
                if (spi_found_w) begin
                    state_d = HRC_LOAD_SPI;                              // [RULE5]
                    src_d   = SRC_SPI;
                end else if (spi_absent_w) begin
                    state_d = HRC_PROBE_EE;                              // [RULE9]
                end
            end
            HRC_LOAD_SPI: begin
                if (load_fin_w) begin
                    state_d = HRC_ATTACHED;
                end
            end
            HRC_PROBE_EE: begin
                if (ee_found_w) begin
                    state_d = HRC_LOAD_EE;                               // [RULE5]
                    src_d   = SRC_EEPROM;
                end else if (ee_absent_w) begin
                    state_d = HRC_LOAD_DEF;                              // [RULE6]
                    src_d   = SRC_DEFAULT;
                end
            end
            HRC_LOAD_EE: begin
                if (load_fin_w) begin
                    state_d = HRC_ATTACHED;
                end
            end
            HRC_LOAD_DEF: begin
                if (load_fin_w) begin
                    state_d = HRC_ATTACHED;
                end
            end
            HRC_ATTACHED: begin
                state_d = HRC_ATTACHED;                                  // [RULE4]
            end
            default: begin
                // An upset state code restarts the whole sequence
                state_d = HRC_RESET;
                src_d   = SRC_NONE;
            end
        endcase
    end

    // Probe timer restarts on each probe state
    always_comb begin
        tmr_d = '0;
        if (probing_w && (state_d == state_q) && !tmo_w) begin
            tmr_d = tmr_q + TW'(1);
        end
    end

    // Loader state register
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state_q <= HRC_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Selected source, kept for status and rewrite permission
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            src_q <= SRC_NONE;
        end else begin
            src_q <= src_d;
        end
    end

    // Probe timer register
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    // Requests to the memory interfaces
    assign o_spi_probe_req = (state_q == HRC_PROBE_SPI);
    assign o_spi_load_req  = (state_q == HRC_LOAD_SPI);
    assign o_ee_probe_req  = (state_q == HRC_PROBE_EE);
    assign o_ee_load_req   = (state_q == HRC_LOAD_EE);
    assign o_def_load_req  = (state_q == HRC_LOAD_DEF);              // [RULE6]

    // Status; attach only once configured
    assign o_cfg_source      = src_q;
    assign o_cfg_done        = (state_q == HRC_ATTACHED);            // [RULE4]
    assign o_upstream_attach = (state_q == HRC_ATTACHED);            // [RULE8]
    assign o_usb_cfg_wr_allow = i_usb_cfg_wr_req && o_cfg_done
                              && (src_q != SRC_DEFAULT);             // [RULE7]
    assign o_tt_count        = 2'(TT_COUNT);                         // [RULE2]
    assign o_tt_np_buffers   = 3'(TT_NP_BUFFERS);                    // [RULE3]

    // Reset pad states for chip select and port power
    assign o_spi_cs_n = hold_w ? 1'b1 : i_spi_cs_n_fn;               // [RULE10]
    assign o_port_power_control_output = hold_w ? '0 : i_port_pwr_fn; // [RULE10]

    // Card media pads held high-impedance with input disabled
    for (genvar g = 0; g < N_CARD; g++) begin : g_card
        hrc_pad_hold #(
            .RST_OE  (1'b0),
            .RST_OUT (1'b0),
            .RST_IE  (1'b0)
        ) u_pad (
            .i_hold    (hold_w),                                     // [RULE10]
            .i_fn_out  (i_card_fn_out[g]),
            .i_fn_oe   (i_card_fn_oe[g]),
            .o_fn_in   (o_card_fn_in[g]),
            .i_pad_in  (i_card_pad_in[g]),
            .o_pad_out (o_card_pad_out[g]),
            .o_pad_oe  (o_card_pad_oe[g])
        );
    end

endmodule // hrc_config_select

/* File: hrc_mem_model.sv */
// Configuration memories answering probe and load requests
`timescale 1ns/1ps
module hrc_mem_model (
    // Requests from the selector
    input  wire logic i_ref_clk, o_spi_probe_req, o_spi_load_req, o_ee_probe_req,
    input  wire logic o_ee_load_req, o_def_load_req,
    // Fitted devices, answering, slow replies
    input  wire logic i_spi_has, i_ee_has, i_ans, i_slow,
    // Answers
    output logic i_spi_probe_done, i_spi_sig_ok, i_spi_load_done, i_ee_probe_done,
    output logic i_ee_sig_ok, i_ee_load_done, i_def_load_done
);
    logic [1:0] cnt_q;
    logic       rdy;
    // Answer after one or three cycles of a standing request
    assign rdy = cnt_q == (i_slow ? 2'h3 : 2'h1);
    assign i_spi_probe_done = i_ans && o_spi_probe_req && rdy;
    assign i_ee_probe_done = i_ans && o_ee_probe_req && rdy;
    // Flags invert outside the answer cycle so no stale value is seen
    assign i_spi_sig_ok = i_spi_probe_done ? i_spi_has : !i_spi_has;
    assign i_ee_sig_ok = i_ee_probe_done ? i_ee_has : !i_ee_has;
    assign i_spi_load_done = o_spi_load_req && rdy; // Firmware image
    assign i_ee_load_done = o_ee_load_req && rdy; // 512-byte image
    assign i_def_load_done = o_def_load_req && rdy;
    // Restart the count after each answer or idle cycle
    always_ff @(posedge i_ref_clk) begin
        cnt_q <= (rdy || !(o_spi_probe_req || o_spi_load_req || o_ee_probe_req
            || o_ee_load_req || o_def_load_req)) ? 2'h0 : cnt_q + 2'h1;
    end
endmodule // hrc_mem_model

/* File: hrc_pad_hold.sv */
`timescale 1ns/1ps
// One pad cell gated into its reset state while hold is active
module hrc_pad_hold
    import hrc_pkg::*;
#(
    parameter logic RST_OE  = 1'b0,
    parameter logic RST_OUT = 1'b0,
    parameter logic RST_IE  = 1'b0
) (
    // Control
    input  wire logic i_hold,
    // Functional side
    input  wire logic i_fn_out,
    input  wire logic i_fn_oe,
    output logic      o_fn_in,
    // Pad side
    input  wire logic i_pad_in,
    output logic      o_pad_out,
    output logic      o_pad_oe
);

    // Reset state overrides the function; the input is blocked too unless RST_IE is set
    assign o_pad_out = i_hold ? RST_OUT : i_fn_out;
    assign o_pad_oe  = i_hold ? RST_OE  : i_fn_oe;       // [RULE1]
    assign o_fn_in   = (i_hold && !RST_IE) ? 1'b0 : i_pad_in; // [RULE1]

endmodule // hrc_pad_hold

/* File: hrc_pkg.sv */
// Constants and types for the hub reset pad and configuration source selector
//
// Contract
// [RULE1] High-impedance pads disable driver and input buffer
// [RULE2] One transaction translator shared by both ports
// [RULE3] Shared translator provides four non-periodic buffers
// [RULE4] Hub fully configured before functioning on host
// [RULE5] Config from 512-byte serial EEPROM or SPI flash
// [RULE6] No external memory: use built-in defaults
// [RULE7] External memory values rewritable through USB
// [RULE8] Attach upstream only after configuration loaded
// [RULE9] Probe SPI flash first, then serial EEPROM
// [RULE10] Reset: chip-select high, power low, card pads Z
package hrc_pkg;

    // Translator figures
    localparam int unsigned TT_COUNT      = 1;
    localparam int unsigned TT_NP_BUFFERS = 4;

    // Serial EEPROM size in bytes and address width
    localparam int unsigned EE_BYTES      = 512;
    localparam int unsigned EE_AW         = 9;

    // Card media pad count and downstream port count
    localparam int unsigned CARD_PADS     = 16;
    localparam int unsigned DN_PORTS      = 2;

    // Probe timeout per memory, in microseconds, and its cycle count at 10 MHz
    localparam int unsigned CLK_MHZ       = 10;
    localparam int unsigned PROBE_US      = 100;
    localparam int unsigned PROBE_CYC     = PROBE_US * CLK_MHZ;

    // Configuration source codes
    localparam logic [1:0] SRC_NONE    = 2'h0;
    localparam logic [1:0] SRC_SPI     = 2'h1;
    localparam logic [1:0] SRC_EEPROM  = 2'h2;
    localparam logic [1:0] SRC_DEFAULT = 2'h3;

    // Loader sequence
    typedef enum logic [2:0] {
        HRC_RESET,
        HRC_PROBE_SPI,
        HRC_LOAD_SPI,
        HRC_PROBE_EE,
        HRC_LOAD_EE,
        HRC_LOAD_DEF,
        HRC_ATTACHED
    } hrc_state_t;

endpackage : hrc_pkg

/* File: tb.sv */
// Testbench for the configuration source selector
`timescale 1ns/1ps
module tb;
    import hrc_pkg::*;
    logic i_ref_clk = 0, i_rstn = 0, i_usb_cfg_wr_req = 0, i_spi_cs_n_fn = 0;
    logic i_spi_probe_done, i_spi_sig_ok, i_spi_load_done, i_ee_probe_done, i_ee_sig_ok;
    logic i_ee_load_done, i_def_load_done, o_spi_probe_req, o_spi_load_req, o_ee_probe_req;
    logic o_ee_load_req, o_def_load_req, o_usb_cfg_wr_allow, o_cfg_done, o_upstream_attach;
    logic o_spi_cs_n, i_spi_has = 0, i_ee_has = 0, i_ans = 0, i_slow = 0;
    logic [1:0] o_cfg_source, o_tt_count, o_port_power_control_output, i_port_pwr_fn = 2'h3;
    logic [2:0] o_tt_np_buffers;
    logic [15:0] i_card_fn_out = '1, i_card_fn_oe = '1, i_card_pad_in = 16'ha5a5;
    logic [15:0] o_card_fn_in, o_card_pad_out, o_card_pad_oe;
    int error_cnt = 0, checked = 0, cyc = 0;
    hrc_config_select #(.PROBE_CYCLES(8)) dut (.*);
    hrc_mem_model mem (.*);
    // Clock and hang guard
    initial forever #50 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic step(); @(posedge i_ref_clk); #1; endtask
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Reset with a far-side setup, then wait for attach with a write pending
    task automatic boot(input logic s, e, a, w);
        i_rstn = 1'b0;
        {i_spi_has, i_ee_has, i_ans, i_slow} = {s, e, a, w};
        i_usb_cfg_wr_req = 1'b1;
        repeat (6) step();
        chk("reset cs_n", 16'h1, 16'(o_spi_cs_n));
        chk("reset power", 16'h0, 16'(o_port_power_control_output));
        chk("reset pad oe", 16'h0, o_card_pad_oe);
        chk("reset pad in", 16'h0, o_card_fn_in);
        chk("reset pad out", 16'h0, o_card_pad_out);
        i_rstn = 1'b1;
        for (int n = 0; n < 100 && o_upstream_attach !== 1'b1; n++) begin
            chk("early write", 16'h0, 16'(o_usb_cfg_wr_allow));
            step();
        end
    endtask
    // Attached state: source, pass-through pads and rewrite permission
    task automatic attached(input logic [1:0] s, input logic a);
        chk("source", 16'(s), 16'(o_cfg_source));
        chk("cfg done", 16'h1, 16'(o_cfg_done));
        chk("attach", 16'h1, 16'(o_upstream_attach));
        chk("power", 16'h3, 16'(o_port_power_control_output));
        chk("cs_n", 16'h0, 16'(o_spi_cs_n));
        chk("pad in", 16'ha5a5, o_card_fn_in);
        chk("pad oe", 16'hffff, o_card_pad_oe);
        chk("pad out", 16'hffff, o_card_pad_out);
        chk("tt count", 16'(TT_COUNT), 16'(o_tt_count));
        chk("tt buffers", 16'(TT_NP_BUFFERS), 16'(o_tt_np_buffers));
        chk("write allow", 16'(a), 16'(o_usb_cfg_wr_allow));
    endtask
    // Flash image found: flash source
    task automatic t_spi(); boot(1, 0, 1, 0); attached(SRC_SPI, 1); endtask
    // No flash image, slow EEPROM: EEPROM source
    task automatic t_ee(); boot(0, 1, 1, 1); attached(SRC_EEPROM, 1); endtask
    // Nothing answers: both probes time out, defaults without rewrite
    task automatic t_def(); boot(0, 0, 0, 0); attached(SRC_DEFAULT, 0); endtask
    // Both probes answer without a signature: defaults without rewrite
    task automatic t_none(); boot(0, 0, 1, 0); attached(SRC_DEFAULT, 0); endtask
    initial begin
        t_spi();
        t_ee();
        t_def();
        t_none();
        finish_test();
    end
endmodule // tb
